// ---- shared/rfp_map.svh ----
// rfp_map.svh: register offsets, field positions, reset values, timing.
// assumes a byte address of 8 bits on the plain register port.
`ifndef RFP_MAP_SVH
`define RFP_MAP_SVH
// ==========================================================
// register byte offsets
`define RFP_A_FLT_EN   8'h00
`define RFP_A_RETRY    8'h04
`define RFP_A_PG_MASK  8'h08
`define RFP_A_OV_THR   8'h0C
`define RFP_A_UV_THR   8'h10
`define RFP_A_FAST_THR 8'h14
`define RFP_A_SLOW_THR 8'h18
`define RFP_A_PK_POS   8'h1C
`define RFP_A_PK_NEG   8'h20
`define RFP_A_OT_FLT   8'h24
`define RFP_A_OT_WARN  8'h28
`define RFP_A_LPF_CFG  8'h2C
`define RFP_A_MISC     8'h30
`define RFP_A_STATUS   8'h34
`define RFP_A_CLEAR    8'h38
// ==========================================================
// fault type bit positions
`define RFP_F_OV    0
`define RFP_F_UV    1
`define RFP_F_OPEN  2
`define RFP_F_FAST  3
`define RFP_F_SLOW  4
`define RFP_F_PEAK  5
`define RFP_F_STAGE 6
`define RFP_F_OT    7
// faults that always pull power-good low
`define RFP_PG_FORCE 8'h7B
// misc register fields
`define RFP_M_INDEF  8
`define RFP_M_PGWARN 9
`define RFP_M_TWFLT  10
// ==========================================================
// reset values
`define RFP_R_FLT_EN  8'hFF
`define RFP_R_RETRY   8'h00
`define RFP_R_PG_MASK 8'h00
`define RFP_R_THR_HI  16'h7FFF
`define RFP_R_THR_LO  16'h8000
`define RFP_R_ZERO16  16'h0000
`define RFP_R_LPF     32'h0010_1042
`define RFP_R_MISC    11'h008
// ==========================================================
// timing: low-side pulse half period
`define RFP_CLK_NS      8
`define RFP_LSS_HALF_NS 1000
`define RFP_LSS_HALF_CYC (`RFP_LSS_HALF_NS / `RFP_CLK_NS)
`endif

// ---- shared/rfp_pkg.sv ----
// rfp_pkg: types of the rail fault protection block.
// assumes nothing beyond a systemverilog compiler.
package rfp_pkg;
  // ========================================================
  // rail state, gray coded along off-run-fault-wait
  typedef enum logic [1:0] {
    RFP_OFF  = 2'b00,
    RFP_RUN  = 2'b01,
    RFP_FLT  = 2'b11,
    RFP_WAIT = 2'b10
  } rfp_state_t;
endpackage : rfp_pkg

// ---- src/rfp_lpf_path.sv ----
// rfp_lpf_path: one total-current path, filter plus threshold timer.
// assumes x is a signed sum sampled every clock.
`include "rfp_map.svh"
module rfp_lpf_path import rfp_pkg::*; #(
  parameter int W  = 19,
  parameter int RW = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic signed [W-1:0]  x,
  input  wire logic signed [15:0]   thr,
  input  wire logic        [3:0]    shift,
  input  wire logic        [RW-1:0] resp,
  output logic                      trip
);
  // ========================================================
  // first order filter
  logic signed [W:0]    acc_reg;   // filter state, one guard bit
  logic signed [W:0]    diff;      // input minus state
  logic        [RW-1:0] cnt_reg;   // cycles spent above threshold
  logic                 trip_reg;  // threshold held long enough

  // difference fits one extra bit as the state stays within the W-bit input range
  always_comb begin
    diff = $signed({x[W-1], x}) - acc_reg;
  end

  // state moves by diff scaled down by the shift
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_reg + (diff >>> shift);
    end
  end

  // ========================================================
  // response timer: trip only after resp cycles above threshold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      trip_reg <= 1'b0;
    end else if (acc_reg > thr) begin
      if (cnt_reg != '1) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      trip_reg <= (cnt_reg >= resp);
    end else begin
      // any dip below the threshold restarts the timer
      cnt_reg  <= '0;
      trip_reg <= 1'b0;
    end
  end

  assign trip = trip_reg;
endmodule : rfp_lpf_path

// ---- src/rfp_rail_protect.sv ----
// rfp_rail_protect: fault monitor and protection for one output rail.
// assumes synchronous sensed inputs, one clock, plain register port,
// and an external soft-start that reports completion.
`include "rfp_map.svh"
// Operation
// - each fault type enabled independently
// - per fault choose latch off or retry
// - good only after soft-start, in window
// - per fault choose effect on good; only open sense and thermal are selectable, the rest always drop good
// - overcurrent, over/undervoltage pull good low
// - voltage faults are digital threshold compares
// - overvoltage: off, fault, alert, pulse low-side
// - undervoltage: off, fault, alert, no pulsing
// - latched rail stays off until enable cycles
// - open sense line suspends the rail
// - summed current feeds fast and slow paths
// - total paths never touch pwm directly
// - phase peak over threshold inverts pwm
// - peak limit indefinite or count-to-fault
// - voltage protection stays active while limiting
// - converter overrange shuts rail down immediately
// - thermal fault shuts down, warning does not
// - warning pin shows warning, valid when enabled
// - good and warning may follow thermal thresholds
// - clear command clears faults and alert
// - shut rail holds pwm in high impedance
module rfp_rail_protect import rfp_pkg::*; #(
  parameter int NPH = 4,
  parameter int CW  = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              enable_in,
  input  wire logic              soft_start_done,
  input  wire logic [15:0]       vout_code,
  input  wire logic              vsense_open,
  input  wire logic [15:0]       temp_code,
  input  wire logic [NPH*CW-1:0] phase_cur,
  input  wire logic [NPH-1:0]    adc_overrange,
  input  wire logic              cycle_start,
  input  wire logic [NPH-1:0]    pwm_in,
  output logic      [NPH-1:0]    pwm_out,
  output logic      [NPH-1:0]    pwm_oe,
  output logic                   rail_run,
  output logic                   low_side_switch,
  output logic                   rail_good_signal_o,
  output logic                   rail_good_signal_oe,
  output logic                   thermal_warning_output_o,
  output logic                   thermal_warning_output_oe,
  output logic                   bus_alert_output_o,
  output logic                   bus_alert_output_oe
);
  localparam int SW = CW + 3;  // room for up to eight phases

  // ========================================================
  // configuration registers
  logic        [7:0]  en_reg;      // fault type enables
  logic        [7:0]  retry_reg;   // 1 = retry, 0 = latch off
  logic        [7:0]  pgm_reg;     // extra faults that drop good
  logic        [15:0] ov_thr_reg;  // overvoltage code
  logic        [15:0] uv_thr_reg;  // undervoltage code
  logic signed [15:0] fast_thr_reg;
  logic signed [15:0] slow_thr_reg;
  logic signed [15:0] pkp_reg;     // positive peak limit
  logic signed [15:0] pkn_reg;     // negative peak limit
  logic        [15:0] ot_f_reg;    // thermal fault level
  logic        [15:0] ot_w_reg;    // thermal warning level
  logic        [31:0] lpf_reg;     // shifts and response times
  logic        [10:0] misc_reg;    // peak count and options

  // ========================================================
  // live state
  rfp_state_t         state_reg;   // rail state
  logic        [7:0]  stat_reg;    // sticky fault bits
  logic               alert_reg;   // alert pin asserted
  logic               ovp_act_reg; // overvoltage discharge active
  logic        [7:0]  pk_cnt_reg;  // consecutive overcurrent cycles
  logic               oc_seen_reg; // overcurrent within this cycle
  logic        [NPH-1:0] pwm_reg;  // limited pwm levels
  logic               pg_bad_reg;  // good pin pulled low
  logic               tw_reg;      // warning pin pulled low
  logic               lss_reg;     // low-side pulse level
  logic        [15:0] lss_cnt_reg; // half period timer
  logic        [31:0] rdata_reg;   // read answer

  logic              clr;          // clear command this cycle
  logic [7:0]        cond;         // raw fault conditions
  logic [7:0]        trip;         // enabled faults while running
  logic [NPH-1:0]    hi;           // phase above positive limit
  logic [NPH-1:0]    lo;           // phase below negative limit
  logic signed [SW-1:0] summed_phase_current;      // summed phase current
  logic              fast_trip;
  logic              slow_trip;
  logic              pk_trip;
  logic              warn_lvl;
  logic              pg_good;

  // sign extend one phase sample to the sum width
  function automatic logic signed [SW-1:0] sx(input logic [CW-1:0] v);
    sx = {{(SW-CW){v[CW-1]}}, v};
  endfunction : sx

  assign clr = wr && (addr == `RFP_A_CLEAR);

  // ========================================================
  // register writes; software owns these, hardware never writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_reg       <= `RFP_R_FLT_EN;
      retry_reg    <= `RFP_R_RETRY;
      pgm_reg      <= `RFP_R_PG_MASK;
      ov_thr_reg   <= `RFP_R_THR_HI;
      uv_thr_reg   <= `RFP_R_ZERO16;
      fast_thr_reg <= `RFP_R_THR_HI;
      slow_thr_reg <= `RFP_R_THR_HI;
      pkp_reg      <= `RFP_R_THR_HI;
      pkn_reg      <= `RFP_R_THR_LO;
      ot_f_reg     <= `RFP_R_THR_HI;
      ot_w_reg     <= `RFP_R_THR_HI;
      lpf_reg      <= `RFP_R_LPF;
      misc_reg     <= `RFP_R_MISC;
    end else if (wr) begin
      unique case (addr)
        `RFP_A_FLT_EN:   en_reg       <= wdata[7:0];
        `RFP_A_RETRY:    retry_reg    <= wdata[7:0];
        `RFP_A_PG_MASK:  pgm_reg      <= wdata[7:0];
        `RFP_A_OV_THR:   ov_thr_reg   <= wdata[15:0];
        `RFP_A_UV_THR:   uv_thr_reg   <= wdata[15:0];
        `RFP_A_FAST_THR: fast_thr_reg <= wdata[15:0];
        `RFP_A_SLOW_THR: slow_thr_reg <= wdata[15:0];
        `RFP_A_PK_POS:   pkp_reg      <= wdata[15:0];
        `RFP_A_PK_NEG:   pkn_reg      <= wdata[15:0];
        `RFP_A_OT_FLT:   ot_f_reg     <= wdata[15:0];
        `RFP_A_OT_WARN:  ot_w_reg     <= wdata[15:0];
        `RFP_A_LPF_CFG:  lpf_reg      <= wdata;
        `RFP_A_MISC:     misc_reg     <= wdata[10:0];
        default: ;  // status, clear and holes store nothing
      endcase
    end
  end

  // ========================================================
  // read port: answer stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (rd) begin
      unique case (addr)
        `RFP_A_FLT_EN:   rdata_reg <= {24'h00_0000, en_reg};
        `RFP_A_RETRY:    rdata_reg <= {24'h00_0000, retry_reg};
        `RFP_A_PG_MASK:  rdata_reg <= {24'h00_0000, pgm_reg};
        `RFP_A_OV_THR:   rdata_reg <= {16'h0000, ov_thr_reg};
        `RFP_A_UV_THR:   rdata_reg <= {16'h0000, uv_thr_reg};
        `RFP_A_FAST_THR: rdata_reg <= {16'h0000, fast_thr_reg};
        `RFP_A_SLOW_THR: rdata_reg <= {16'h0000, slow_thr_reg};
        `RFP_A_PK_POS:   rdata_reg <= {16'h0000, pkp_reg};
        `RFP_A_PK_NEG:   rdata_reg <= {16'h0000, pkn_reg};
        `RFP_A_OT_FLT:   rdata_reg <= {16'h0000, ot_f_reg};
        `RFP_A_OT_WARN:  rdata_reg <= {16'h0000, ot_w_reg};
        `RFP_A_LPF_CFG:  rdata_reg <= lpf_reg;
        `RFP_A_MISC:     rdata_reg <= {21'h00_0000, misc_reg};
        `RFP_A_STATUS:   rdata_reg <= {12'h000, pk_cnt_reg,
                                       state_reg, tw_reg,
                                       alert_reg, stat_reg};
        default:         rdata_reg <= '0;  // holes read zero
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end
  assign rdata = rdata_reg;

  // ========================================================
  // per-phase peak compare
  for (genvar g = 0; g < NPH; g++) begin : g_ph
    assign hi[g] = $signed(phase_cur[g*CW +: CW]) > pkp_reg;
    assign lo[g] = $signed(phase_cur[g*CW +: CW]) < pkn_reg;
  end

  // total current of the rail
  always_comb begin
    summed_phase_current = '0;
    for (int i = 0; i < NPH; i++) begin
      summed_phase_current = summed_phase_current + sx(phase_cur[i*CW +: CW]);
    end
  end

  // fast and slow paths share the sum, own filter and timing
  rfp_lpf_path #(.W(SW), .RW(16)) u_fast (
    .clk   (clk),
    .rst_n (rst_n),
    .x     (summed_phase_current),
    .thr   (fast_thr_reg),
    .shift (lpf_reg[3:0]),
    .resp  ({8'h00, lpf_reg[15:8]}),
    .trip  (fast_trip)
  );
  rfp_lpf_path #(.W(SW), .RW(16)) u_slow (
    .clk   (clk),
    .rst_n (rst_n),
    .x     (summed_phase_current),
    .thr   (slow_thr_reg),
    .shift (lpf_reg[7:4]),
    .resp  (lpf_reg[31:16]),
    .trip  (slow_trip)
  );

  // ========================================================
  // consecutive overcurrent counter, judged at each cycle start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pk_cnt_reg  <= '0;
      oc_seen_reg <= 1'b0;
    end else if (cycle_start) begin
      oc_seen_reg <= 1'b0;
      if (oc_seen_reg || (|(hi | lo))) begin
        if (pk_cnt_reg != 8'hFF) begin
          pk_cnt_reg <= pk_cnt_reg + 8'h01;
        end
      end else begin
        pk_cnt_reg <= '0;
      end
    end else if (|(hi | lo)) begin
      oc_seen_reg <= 1'b1;
    end
  end

  // indefinite mode never trips; count mode trips at the limit
  assign pk_trip = !misc_reg[`RFP_M_INDEF] && (pk_cnt_reg != 8'h00)
                   && (pk_cnt_reg >= misc_reg[7:0]);

  // ========================================================
  // fault conditions; voltage checks stay live while limiting
  always_comb begin
    cond = '0;
    cond[`RFP_F_OV]    = vout_code > ov_thr_reg;
    cond[`RFP_F_UV]    = soft_start_done
                         && (vout_code < uv_thr_reg);
    cond[`RFP_F_OPEN]  = vsense_open;
    cond[`RFP_F_FAST]  = fast_trip;
    cond[`RFP_F_SLOW]  = slow_trip;
    cond[`RFP_F_PEAK]  = pk_trip;
    cond[`RFP_F_STAGE] = |adc_overrange;
    cond[`RFP_F_OT]    = temp_code >= ot_f_reg;
  end
  assign trip = (state_reg == RFP_RUN) ? (cond & en_reg) : 8'h00;

  // ========================================================
  // rail state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= RFP_OFF;
    end else begin
      unique case (state_reg)
        RFP_OFF: begin
          if (enable_in) begin
            state_reg <= RFP_RUN;
          end
        end
        RFP_RUN: begin
          if (|trip) begin
            // retry only when every tripping type allows it
            state_reg <= ((trip & ~retry_reg) == 8'h00) ?
                         RFP_WAIT : RFP_FLT;
          end else if (!enable_in) begin
            state_reg <= RFP_OFF;
          end
        end
        RFP_FLT: begin
          if (!enable_in) begin
            state_reg <= RFP_OFF;
          end
        end
        RFP_WAIT: begin
          // restart only once the cause has gone away
          if (!enable_in || ((cond & en_reg) == 8'h00)) begin
            state_reg <= RFP_OFF;
          end
        end
      endcase
    end
  end

  // total paths act only through this state, pwm shape untouched
  assign rail_run = (state_reg == RFP_RUN);
  assign pwm_oe   = {NPH{rail_run}};

  // ========================================================
  // sticky fault bits and alert; a new trip beats a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_reg  <= '0;
      alert_reg <= 1'b0;
    end else begin
      stat_reg  <= (clr ? 8'h00 : stat_reg) | trip;
      alert_reg <= (clr ? 1'b0 : alert_reg) | (|trip);
    end
  end
  assign bus_alert_output_o  = 1'b0;
  assign bus_alert_output_oe = alert_reg;

  // ========================================================
  // pwm limiter: invert toward the threshold within the cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_reg <= '0;
    end else begin
      pwm_reg <= (pwm_in & ~hi) | lo;
    end
  end
  assign pwm_out = pwm_reg;

  // ========================================================
  // overvoltage discharge through the low-side switch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovp_act_reg <= 1'b0;
    end else if (trip[`RFP_F_OV]) begin
      ovp_act_reg <= 1'b1;
    end else if (!cond[`RFP_F_OV]) begin
      ovp_act_reg <= 1'b0;  // stops once below threshold
    end
  end

  // pulse train only while discharging; undervoltage never starts it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lss_reg     <= 1'b0;
      lss_cnt_reg <= '0;
    end else if (!ovp_act_reg || !cond[`RFP_F_OV]) begin
      lss_reg     <= 1'b0;
      lss_cnt_reg <= '0;
    end else if (lss_cnt_reg == 16'(`RFP_LSS_HALF_CYC - 1)) begin
      lss_reg     <= !lss_reg;
      lss_cnt_reg <= '0;
    end else begin
      lss_cnt_reg <= lss_cnt_reg + 16'h0001;
    end
  end
  assign low_side_switch = lss_reg;

  // ========================================================
  // power good and thermal warning pins
  assign warn_lvl = misc_reg[`RFP_M_TWFLT] ?
                    (temp_code >= ot_f_reg) :
                    (temp_code >= ot_w_reg);
  assign pg_good = rail_run && soft_start_done
                   && (vout_code <= ov_thr_reg)
                   && (vout_code >= uv_thr_reg)
                   && ((cond & `RFP_PG_FORCE) == 8'h00)
                   && ((cond & pgm_reg) == 8'h00)
                   && !(misc_reg[`RFP_M_PGWARN]
                        && (temp_code >= ot_w_reg));

  // warning stays quiet until the controller is enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_bad_reg <= 1'b1;
      tw_reg     <= 1'b0;
    end else begin
      pg_bad_reg <= !pg_good;
      tw_reg     <= enable_in && warn_lvl;
    end
  end
  assign rail_good_signal_o        = 1'b0;
  assign rail_good_signal_oe       = pg_bad_reg;
  assign thermal_warning_output_o  = 1'b0;
  assign thermal_warning_output_oe = tw_reg;

  // ========================================================
  // checks
  AST_TRIP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (|trip) |=> (pwm_oe == '0) && !rail_run)
    else $error("rail still driving after a trip");
  AST_EN_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    (rail_run && enable_in && ((cond & en_reg) == 8'h00)) |=> rail_run)
    else $error("rail stopped with no enabled fault");
  AST_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == RFP_FLT && enable_in) |=> state_reg == RFP_FLT)
    else $error("latched fault released without enable cycle");
  AST_RETRY: assert property (@(posedge clk) disable iff (!rst_n)
    ((|trip) && ((trip & ~retry_reg) != 8'h00)) |=> state_reg == RFP_FLT)
    else $error("latching fault did not latch");
  AST_ALERT: assert property (@(posedge clk) disable iff (!rst_n)
    (|trip) |=> bus_alert_output_oe
      && ((stat_reg & $past(trip)) == $past(trip)))
    else $error("trip not reported");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (clr && (trip == 8'h00)) |=> !bus_alert_output_oe && stat_reg == 0)
    else $error("clear command left faults");
  AST_PG_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    (cond[`RFP_F_OV] || cond[`RFP_F_UV] || fast_trip)
      |=> rail_good_signal_oe)
    else $error("good not pulled low on fault");
  AST_PG_SS: assert property (@(posedge clk) disable iff (!rst_n)
    !soft_start_done |=> rail_good_signal_oe)
    else $error("good released before soft-start done");
  AST_PEAK: assert property (@(posedge clk) disable iff (!rst_n)
    (hi[0] && !lo[0]) |=> !pwm_out[0])
    else $error("peak limit did not pull pwm low");
  AST_LSS: assert property (@(posedge clk) disable iff (!rst_n)
    low_side_switch |-> ovp_act_reg)
    else $error("low-side pulse without overvoltage");
  AST_THERMAL_WARNING_OUTPUT: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_in |=> !thermal_warning_output_oe)
    else $error("warning driven while disabled");
  AST_PK_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    (cycle_start && !oc_seen_reg && ((hi | lo) == '0)) |=> pk_cnt_reg == 0)
    else $error("clean cycle kept overcurrent count");
endmodule : rfp_rail_protect

// ---- bench/rfp_pins_model.sv ----
// rfp_pins_model: the board side of the three open-drain status pins.
// assumes each oe high means the rail block pulls that pin to o.
module rfp_pins_model (
  input  wire logic good_o,
  input  wire logic good_oe,
  input  wire logic warn_o,
  input  wire logic warn_oe,
  input  wire logic alert_o,
  input  wire logic alert_oe,
  output logic      good_pin,
  output logic      warn_pin,
  output logic      alert_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pull-ups: a released pin reads high, never a stale level
  assign good_pin  = good_oe  ? good_o  : 1'b1;
  assign warn_pin  = warn_oe  ? warn_o  : 1'b1;
  assign alert_pin = alert_oe ? alert_o : 1'b1;
endmodule : rfp_pins_model

// ---- bench/rfp_rail_protect_tb.sv ----
// rfp_rail_protect_tb: register-call tests of one protected rail.
// assumes the pins model above and a 125 MHz clock.
`include "rfp_map.svh"
module rfp_rail_protect_tb import rfp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals, named as the design ports
  logic clk, rst_n, wr, rd, enable_in, soft_start_done, vsense_open;
  logic cycle_start, rail_run, low_side_switch;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] vout_code, temp_code;
  logic [63:0] phase_cur;
  logic [3:0] adc_overrange, pwm_in, pwm_out, pwm_oe;
  logic rail_good_signal_o, rail_good_signal_oe, bus_alert_output_o;
  logic thermal_warning_output_o, thermal_warning_output_oe;
  logic bus_alert_output_oe, good_pin, warn_pin, alert_pin;
  int mismatches, n_checks;
  rfp_rail_protect dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .enable_in(enable_in), .soft_start_done(soft_start_done),
    .vout_code(vout_code), .vsense_open(vsense_open),
    .temp_code(temp_code), .phase_cur(phase_cur),
    .adc_overrange(adc_overrange), .cycle_start(cycle_start),
    .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .rail_run(rail_run), .low_side_switch(low_side_switch),
    .rail_good_signal_o(rail_good_signal_o),
    .rail_good_signal_oe(rail_good_signal_oe),
    .thermal_warning_output_o(thermal_warning_output_o),
    .thermal_warning_output_oe(thermal_warning_output_oe),
    .bus_alert_output_o(bus_alert_output_o),
    .bus_alert_output_oe(bus_alert_output_oe));
  rfp_pins_model pins (.good_o(rail_good_signal_o),
    .good_oe(rail_good_signal_oe), .warn_o(thermal_warning_output_o),
    .warn_oe(thermal_warning_output_oe), .alert_o(bus_alert_output_o),
    .alert_oe(bus_alert_output_oe), .good_pin(good_pin),
    .warn_pin(warn_pin), .alert_pin(alert_pin));
  // ==========================================================
  // clock, and a watchdog well beyond the few hundred cycles used
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  // ==========================================================
  // bus calls and comparison helpers
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  // bounded wait for the rail to come up again
  task automatic wait_run();
    for (int i = 0; i < 40 && rail_run !== 1'b1; i++) @(posedge clk);
    #1;
  endtask : wait_run
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // ==========================================================
  // main sequence; sense-open and overrange held quiet, temperature raised only in the last test
  initial begin
    {rst_n, wr, rd, enable_in, soft_start_done, vsense_open} = 0;
    {cycle_start, addr, wdata, pwm_in, adc_overrange, phase_cur} = 0;
    vout_code = 16'h0800;
    temp_code = 16'h0010;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    #1 chk(good_pin === 0 && alert_pin === 1, "reset pins");
    rd_reg(`RFP_A_FLT_EN, d);
    chk(d === 32'h0000_00ff, "enables reset");
    wr_reg(`RFP_A_OV_THR, 32'h0000_1000);
    wr_reg(`RFP_A_UV_THR, 32'h0000_0400);
    enable_in <= 1;
    step(6);
    chk(good_pin === 0, "good before soft start");
    @(posedge clk) soft_start_done <= 1;
    wait_run();
    step(3);
    chk(good_pin === 1 && pwm_oe === 4'hf, "rail up");
    $display("test startup done");
    // peak limit inverts only the offending phase
    wr_reg(`RFP_A_PK_POS, 32'h0000_0100);
    pwm_in <= 4'b0101;
    phase_cur[15:0] <= 16'h0200;
    step(3);
    chk(pwm_out === 4'b0100 && rail_run === 1, "peak invert");
    @(posedge clk) phase_cur <= 0;
    step(3);
    chk(pwm_out === 4'b0101, "peak released");
    $display("test peak done");
    // overvoltage: off, alert, good low, discharge pulses
    @(posedge clk) vout_code <= 16'h2000;
    step(2);
    chk(rail_run === 0 && pwm_oe === 0 && alert_pin === 0, "ov");
    chk(good_pin === 0, "ov good");
    for (int i = 0; i < 130 && low_side_switch !== 1'b1; i++) step(1);
    chk(low_side_switch === 1, "ov pulses");
    @(posedge clk) vout_code <= 16'h0800;
    step(3);
    chk(low_side_switch === 0, "pulses stop");
    step(20);
    chk(rail_run === 0, "latched off");
    wr_reg(`RFP_A_CLEAR, 32'h0000_0001);
    rd_reg(`RFP_A_STATUS, d);
    chk((d & 32'h0000_01ff) === 0 && alert_pin === 1, "clear");
    @(posedge clk) enable_in <= 0;
    step(3);
    @(posedge clk) enable_in <= 1;
    wait_run();
    chk(rail_run === 1, "enable cycled");
    $display("test overvoltage done");
    // undervoltage with retry: no pulses, restarts when clear
    wr_reg(`RFP_A_RETRY, 32'h0000_0002);
    vout_code <= 16'h0100;
    step(3);
    chk(rail_run === 0 && low_side_switch === 0, "uv off");
    rd_reg(`RFP_A_STATUS, d);
    chk(d[1] === 1 && d[8] === 1, "uv status");
    @(posedge clk) vout_code <= 16'h0800;
    wait_run();
    chk(rail_run === 1, "uv retry");
    $display("test retry done");
    // overvoltage masked off: rail stays, good still drops
    wr_reg(`RFP_A_FLT_EN, 32'h0000_00fe);
    vout_code <= 16'h2000;
    step(5);
    chk(rail_run === 1 && good_pin === 0, "ov disabled");
    $display("test enables done");
    // peak count: eight over-limit cycles fault, clean cycles clear it
    wr_reg(`RFP_A_RETRY, 32'h0000_0022);
    phase_cur[15:0] <= 16'h0200;
    repeat (8) begin
      @(posedge clk) cycle_start <= 1;
      @(posedge clk) cycle_start <= 0;
    end
    step(2);
    chk(rail_run === 0, "peak count fault");
    rd_reg(`RFP_A_STATUS, d);
    chk(d[5] === 1 && d[19:12] === 8 && d[11:10] === 2, "pk stat");
    @(posedge clk) phase_cur <= 0;
    repeat (2) begin
      @(posedge clk) cycle_start <= 1;
      @(posedge clk) cycle_start <= 0;
    end
    wait_run();
    rd_reg(`RFP_A_STATUS, d);
    chk(rail_run === 1 && d[19:12] === 0, "pk clean");
    $display("test peak count done");
    // thermal: warning pin only, then the fault level shuts down
    wr_reg(`RFP_A_OT_WARN, 32'h0000_0040);
    temp_code <= 16'h0050;
    step(2);
    chk(warn_pin === 0 && rail_run === 1, "warn only");
    wr_reg(`RFP_A_OT_FLT, 32'h0000_0048);
    step(2);
    chk(rail_run === 0 && warn_pin === 0, "thermal fault");
    $display("test thermal done");
    test_done();
  end
endmodule : rfp_rail_protect_tb
